// File: include/cms_map.svh
// Constants for the charge mode supervisor
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH
`define CMS_ADDR_CTRL 4'h0
`define CMS_ADDR_STAT 4'h4
`define CMS_ADDR_LIMIT 4'h8
`define CMS_ADDR_MINUTES 4'hC
`define CMS_CTRL_RESET 32'h0000_0000
`define CMS_STAT_FAST_BIT 0
`define CMS_STAT_TIMER_BIT 1
`define CMS_STAT_HOT_BIT 2
`define CMS_STAT_FULL_BIT 4
`define CMS_STAT_EXPIRED_BIT 3
`define CMS_STAT_SLOPE_BIT 5
`define CMS_HOLDOFF_S 160
`define CMS_LIM_111 9'd283
`define CMS_LIM_110 9'd247
`define CMS_LIM_101 9'd212
`define CMS_LIM_100 9'd177
`define CMS_LIM_011 9'd141
`define CMS_LIM_010 9'd106
`define CMS_LIM_001 9'd71
`define CMS_LIM_NONE 9'd0
`define CMS_RESP_OKAY 2'b00
`define CMS_RESP_SLVERR 2'b10
`endif

// File: include/cms_pkg.sv
// Types for the charge mode supervisor
package cms_pkg;
  typedef struct packed {
    logic below_window;
    logic above_window;
    logic cold;
    logic hot;
    logic uvlo;
    logic slope_event;
    logic holdoff_done;
    logic timer_expired;
  } cms_cond_t;
  typedef struct packed {
    logic lower;
    logic thermistor;
    logic upper;
  } cms_prog_t;
  typedef enum logic [1:0] {CMS_RD_IDLE, CMS_RD_RESP} cms_rd_state_t;
endpackage

// File: rtl/cms_supervisor.sv
// Fast/trickle mode supervisor with AXI4-Lite status and control
`timescale 1ns/10ps
`include "cms_map.svh"
module cms_supervisor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Condition flags from comparators and timer (asynchronous)
  input wire cms_pkg::cms_cond_t cond_in,
  // Programming inputs above select threshold (asynchronous)
  input wire cms_pkg::cms_prog_t prog_above_in,
  // Fast/trickle open-collector pin, active low
  output logic fast_trickle_n_o,
  output logic fast_trickle_n_oe,
  // Reset pulse and hold to backup timer
  output logic timer_reset,
  output logic timer_enable,
  output logic [8:0] timer_limit_min,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  cms_pkg::cms_cond_t cond_s1, cond;
  cms_pkg::cms_prog_t prog_s1, prog;
  // Two stages on every pin; a slope pulse must span a whole cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_s1 <= '0;
      cond <= '0;
      prog_s1 <= '0;
      prog <= '0;
    end else begin
      cond_s1 <= cond_in;
      cond <= cond_s1;
      prog_s1 <= prog_above_in;
      prog <= prog_s1;
    end
  end

  // ----------------------------------------------------------------
  // Mode select and limit decode
  // ----------------------------------------------------------------
  // temperature mode when no input high
  // timer mode when any input high
  wire timer_mode = prog.lower | prog.thermistor | prog.upper;
  wire [2:0] prog_code = {prog.lower, prog.thermistor, prog.upper};
  logic [8:0] limit_dec;
  always_comb begin
    case (prog_code)
      3'b111: limit_dec = `CMS_LIM_111;
      3'b110: limit_dec = `CMS_LIM_110;
      3'b101: limit_dec = `CMS_LIM_101;
      3'b100: limit_dec = `CMS_LIM_100;
      3'b011: limit_dec = `CMS_LIM_011;
      3'b010: limit_dec = `CMS_LIM_010;
      3'b001: limit_dec = `CMS_LIM_001;
      default: limit_dec = `CMS_LIM_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Reset pulse and latches
  // ----------------------------------------------------------------
  logic in_window_q, uvlo_q, over_temp, full_latch, expired_latch, slope_pend;
  logic ctrl_clear;
  wire in_window = !cond.below_window && !cond.above_window;
  wire window_entry = in_window && !in_window_q;
  // pulse on window entry, supply recovery or software clear
  wire reset_pulse = window_entry || (uvlo_q && !cond.uvlo) || ctrl_clear;
  wire latch_clr = reset_pulse || cond.uvlo;
  // hot sets latch only in temperature mode
  wire hot_set = !timer_mode && cond.hot;
  // second slope event after holdoff, sense in window
  wire slope_seen = in_window && cond.holdoff_done && cond.slope_event;
  wire slope_full = slope_seen && slope_pend;
  wire exp_set = timer_mode && cond.timer_expired;
  // in temperature mode, cold forces trickle only while asserted
  wire cold_hold = !timer_mode && cond.cold;
  // fast only when every condition is good
  wire next_fast = in_window && !cond.uvlo && !cold_hold && !over_temp && !hot_set
    && !full_latch && !expired_latch;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_window_q <= 1'b1;
      uvlo_q <= 1'b0;
      over_temp <= 1'b0;
      full_latch <= 1'b0;
      expired_latch <= 1'b0;
      slope_pend <= 1'b0;
    end else begin
      in_window_q <= in_window;
      uvlo_q <= cond.uvlo;
      // hot set wins; clear otherwise on pulse or lockout
      over_temp <= hot_set || (over_temp && !latch_clr);
      full_latch <= slope_full || (full_latch && !reset_pulse);
      expired_latch <= exp_set || (expired_latch && !latch_clr);
      // a fresh event wins over a clear in the same cycle
      if (slope_seen)
        slope_pend <= 1'b1;
      // below window clears pending slope event
      else if (cond.below_window || reset_pulse)
        slope_pend <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_trickle_n_o <= 1'b0;
      fast_trickle_n_oe <= 1'b0;
      timer_reset <= 1'b1;
      timer_enable <= 1'b0;
      timer_limit_min <= `CMS_LIM_NONE;
    end else begin
      // pull low for trickle, release for fast
      // Data stays low; only the enable moves, as on an open-collector pin
      fast_trickle_n_o <= 1'b0;
      fast_trickle_n_oe <= !next_fast;
      // lockout and pulses reset the timer
      timer_reset <= latch_clr;
      // timer held off in temperature mode
      timer_enable <= timer_mode && !cond.uvlo;
      timer_limit_min <= limit_dec;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Writes to control bit 0 issue a software reset pulse; it cannot mask hardware sets.
  // Data bit kept until the address arrives, so either order works
  logic aw_got, w_got, w_bit0;
  logic [3:0] aw_addr;
  logic [31:0] stat_word;
  wire do_write = aw_got && w_got && !s_axi_bvalid;
  wire wr_ctrl = aw_addr == `CMS_ADDR_CTRL;
  // Status fields placed by the map so software and logic agree
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`CMS_STAT_FAST_BIT] = !fast_trickle_n_oe;
    stat_word[`CMS_STAT_TIMER_BIT] = timer_mode;
    stat_word[`CMS_STAT_HOT_BIT] = over_temp;
    stat_word[`CMS_STAT_EXPIRED_BIT] = expired_latch;
    stat_word[`CMS_STAT_FULL_BIT] = full_latch;
    stat_word[`CMS_STAT_SLOPE_BIT] = slope_pend;
  end
  wire rd_ok = s_axi_araddr == `CMS_ADDR_STAT || s_axi_araddr == `CMS_ADDR_CTRL
    || s_axi_araddr == `CMS_ADDR_MINUTES;
  wire [31:0] rd_word = s_axi_araddr == `CMS_ADDR_STAT ? stat_word :
    s_axi_araddr == `CMS_ADDR_MINUTES ? {23'h0, timer_limit_min} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 4'h0;
      ctrl_clear <= 1'b0;
      w_bit0 <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMS_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CMS_RESP_OKAY;
    end else begin
      ctrl_clear <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_bit0 <= s_axi_wstrb[0] && s_axi_wdata[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ctrl ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
        ctrl_clear <= wr_ctrl && w_bit0;
        aw_got <= 1'b0;
        w_got <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? `CMS_RESP_OKAY : `CMS_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  hot_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    hot_set |=> over_temp) else $error("hot flag did not set latch");
  latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    over_temp && !latch_clr |=> over_temp) else $error("latch cleared without pulse");
  window_trickle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !in_window |=> fast_trickle_n_oe) else $error("out of window not trickle");
  entry_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    window_entry |=> timer_reset) else $error("no reset on window entry");
  uvlo_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cond.uvlo |=> fast_trickle_n_oe && timer_reset) else $error("lockout not held");
  expiry_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    exp_set |=> expired_latch) else $error("expiry not latched");
  full_latch_a: assert property (@(posedge aclk) disable iff (!aresetn)
    slope_full |=> full_latch ##1 fast_trickle_n_oe) else $error("full charge not latched");
  slope_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cond.below_window |=> !slope_pend) else $error("slope event not cleared");
  temp_timer_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !timer_mode |=> !timer_enable) else $error("timer enabled in temperature mode");
  temp_limit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !timer_mode |=> timer_limit_min == `CMS_LIM_NONE) else $error("limit set in temperature mode");
  timer_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_mode && !cond.uvlo |=> timer_enable) else $error("timer not enabled in timer mode");
  cold_trickle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cold_hold |=> fast_trickle_n_oe) else $error("cold flag did not force trickle");
  hot_trickle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    over_temp |=> fast_trickle_n_oe) else $error("over temperature not trickle");
  supply_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    uvlo_q && !cond.uvlo |=> timer_reset) else $error("no reset on supply recovery");
  full_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    full_latch && !reset_pulse |=> full_latch) else $error("full latch released early");
  slope_pend_a: assert property (@(posedge aclk) disable iff (!aresetn)
    slope_seen |=> slope_pend) else $error("slope event not held");
  expiry_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    expired_latch && !latch_clr |=> expired_latch) else $error("expiry released early");
  uvlo_timer_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cond.uvlo |=> !timer_enable) else $error("timer enabled in lockout");
  fast_good_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !fast_trickle_n_oe |-> $past(in_window) && !$past(cond.uvlo) && !$past(expired_latch)
    && !$past(over_temp)) else $error("fast without good conditions");
  limit_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
    prog_code == 3'b111 |=> timer_limit_min == `CMS_LIM_111) else $error("top limit wrong");

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  sw_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_clear |=> timer_reset) else $error("software clear gave no pulse");
  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> s_axi_bvalid) else $error("write response missing");
  write_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  read_busy_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule

// File: dv/cms_regulator.sv
// Charging regulator model reading the fast/trickle pin
`timescale 1ns/10ps
module cms_regulator (
  // Open-collector pin from the supervisor
  input wire logic drive_n,
  input wire logic drive_oe,
  // Mode seen by the regulator
  output logic fast_mode
);
  // pin level decode
  // Pull-up on the pin: a released pin reads high, never the last driven value
  assign fast_mode = drive_oe ? drive_n : 1'b1;
endmodule

// File: dv/cms_supervisor_test.sv
// Testbench for the charge mode supervisor
`timescale 1ns/10ps
`include "cms_map.svh"
module cms_supervisor_test;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  cms_pkg::cms_cond_t cond = '0;
  cms_pkg::cms_prog_t prog = '0;
  logic ft_n, ft_oe, t_rst, t_en, fast, awready, wready, bvalid, arready, rvalid;
  logic [8:0] lim;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, dat;
  logic [1:0] bresp, rresp, resp;
  int miscompares = 0, checks_done = 0, cyc = 0, pulses = 0, p0;
  logic [8:0] lims [8] = '{9'h000, 9'h047, 9'h06A, 9'h08D, 9'h0B1, 9'h0D4, 9'h0F7, 9'h11B};
  cms_supervisor u_cms_supervisor (.aclk(aclk), .aresetn(aresetn), .cond_in(cond),
    .prog_above_in(prog), .fast_trickle_n_o(ft_n), .fast_trickle_n_oe(ft_oe),
    .timer_reset(t_rst), .timer_enable(t_en), .timer_limit_min(lim),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  cms_regulator u_cms_regulator (.drive_n(ft_n), .drive_oe(ft_oe), .fast_mode(fast));
  always #2 aclk = ~aclk;
  // Watchdog well above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (t_rst) pulses++;
    if (cyc == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic st;
    repeat (6) @(posedge aclk);
  endtask
  task automatic slp;
    cond.slope_event <= 1'b1;
    @(posedge aclk);
    cond.slope_event <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic win;
    cond.below_window <= 1'b1;
    st();
    cond.below_window <= 1'b0;
    st();
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic finish_test;
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    st();
    chk("fast", fast, 32'h1);
    chk("tmr_en", t_en, 32'h0);
    for (int i = 7; i >= 1; i--) begin
      prog <= i[2:0];
      st();
      chk("limit", lim, lims[i]);
      chk("tmr_en", t_en, 32'h1);
    end
    rd(4'hC);
    chk("minutes", dat, {23'h0, lims[1]});
    // Temperature mode, backup timer disabled by the outside bias
    prog <= 3'h0;
    st();
    chk("tmr_en", t_en, 32'h0);
    chk("limit", lim, 32'h0);
    cond.cold <= 1'b1;
    st();
    chk("fast", fast, 32'h0);
    cond.cold <= 1'b0;
    st();
    chk("fast", fast, 32'h1);
    cond.hot <= 1'b1;
    st();
    cond.hot <= 1'b0;
    st();
    chk("fast", fast, 32'h0);
    rd(4'h4);
    chk("hot", dat[`CMS_STAT_HOT_BIT], 32'h1);
    cond.below_window <= 1'b1;
    st();
    chk("fast", fast, 32'h0);
    p0 = pulses;
    cond.below_window <= 1'b0;
    st();
    chk("fast", fast, 32'h1);
    chk("pulse", pulses - p0, 32'h1);
    cond.above_window <= 1'b1;
    st();
    chk("fast", fast, 32'h0);
    cond.above_window <= 1'b0;
    st();
    // Slope events ignored until holdoff has run out
    slp();
    slp();
    st();
    chk("fast", fast, 32'h1);
    win();
    cond.holdoff_done <= 1'b1;
    slp();
    slp();
    st();
    chk("fast", fast, 32'h0);
    rd(4'h4);
    chk("full", dat[`CMS_STAT_FULL_BIT], 32'h1);
    wr(4'h0, 32'h1);
    chk("bresp", resp, 32'h0);
    st();
    chk("fast", fast, 32'h1);
    // Low sense alone clears a pending event, before any window entry
    slp();
    rd(4'h4);
    chk("slope", dat[`CMS_STAT_SLOPE_BIT], 32'h1);
    cond.below_window <= 1'b1;
    st();
    rd(4'h4);
    chk("slope", dat[`CMS_STAT_SLOPE_BIT], 32'h0);
    cond.below_window <= 1'b0;
    st();
    slp();
    st();
    chk("fast", fast, 32'h1);
    prog <= 3'h7;
    cond.timer_expired <= 1'b1;
    st();
    cond.timer_expired <= 1'b0;
    st();
    chk("fast", fast, 32'h0);
    rd(4'h4);
    chk("expired", dat[`CMS_STAT_EXPIRED_BIT], 32'h1);
    win();
    chk("fast", fast, 32'h1);
    cond.uvlo <= 1'b1;
    st();
    chk("fast", fast, 32'h0);
    chk("tmr_rst", t_rst, 32'h1);
    chk("tmr_en", t_en, 32'h0);
    cond.uvlo <= 1'b0;
    st();
    chk("fast", fast, 32'h1);
    wr(4'h8, 32'h1);
    chk("bresp", resp, {30'h0, `CMS_RESP_SLVERR});
    rd(4'h8);
    chk("rresp", resp, {30'h0, `CMS_RESP_SLVERR});
    chk("rdata", dat, 32'h0);
    // Power cycle leaves a latched trickle and starts fast again
    prog <= 3'h0;
    cond.hot <= 1'b1;
    st();
    cond.hot <= 1'b0;
    st();
    chk("fast", fast, 32'h0);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    st();
    chk("fast", fast, 32'h1);
    rd(4'h4);
    chk("hot", dat[`CMS_STAT_HOT_BIT], 32'h0);
    finish_test();
  end
endmodule
